// [rtl/apc_regs.sv]
`timescale 1ns/1ps
`include "apc_defs.svh"

module apc_regs
(
    input  wire logic                       CLK,
    input  wire logic                       SRST,
    input  wire logic [7:0]                 REG_ADDR,
    input  wire logic                       REG_WR,
    input  wire logic [7:0]                 REG_WDATA,
    input  wire logic                       REG_RD,
    output logic      [7:0]                 REG_RDATA,
    input  wire logic                       SAMPLE_TICK,
    input  wire logic [3:0]                 SYNC_EN,
    input  wire apc_pkg::apc_vol_array_type VOL_SET,
    input  wire logic [3:0]                 VOL_BYPASS,
    input  wire logic                       MIC_CLK,
    input  wire logic                       MIC_DATA,
    input  wire logic [1:0]                 ADC_BIT,
    output apc_pkg::apc_vol_array_type      VOL_APPLIED,
    output logic      [1:0]                 CAPTURE_RATE,
    output logic      [1:0]                 HIGHPASS_SEL,
    output logic                            DECIM_SRC_MIC,
    output logic      [1:0]                 DECIM_IN,
    output logic      [1:0]                 MIC_SIGN,
    output logic      [1:0]                 CH_ACTIVE,
    output logic      [1:0]                 CH_MISMATCH
);
    import apc_pkg::*;

    apc_state_type     state_reg;
    apc_state_type     state_next;
    apc_vol_array_type ramp_level;

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++)
        begin : g_ramp
            apc_ramp #(
                .STEP_SAMPLES (`APC_STEP_SAMPLES)
            ) u_ramp (
                .clk         (CLK),
                .srst        (SRST),
                .sample_tick (SAMPLE_TICK),
                .sync_en     (SYNC_EN[ch]),
                .target      (VOL_SET[ch]),
                .level       (ramp_level[ch])
            );
        end
    endgenerate

    function automatic logic channel_muted(input logic [7:0] upper, input int idx);
        logic m;
        m = 1'b0;
        if (idx == 2)
        begin
            m = upper[`APC_BIT_THIRD_MUTE];
        end
        else if (idx == 3)
        begin
            m = upper[`APC_BIT_FOURTH_MUTE];
        end
        return m;
    endfunction

    always_comb
    begin
        state_next = state_reg;

        // whole-byte writes keep reserved bits as written
        if (REG_WR && REG_ADDR == `APC_ADDR_UPPER)
        begin
            state_next.upper = REG_WDATA;
        end
        if (REG_WR && REG_ADDR == `APC_ADDR_LOWER)
        begin
            state_next.lower = REG_WDATA;
        end
        // read sees the value before a same-cycle write
        if (REG_RD)
        begin
            if (REG_ADDR == `APC_ADDR_UPPER)
            begin
                state_next.rdata = state_reg.upper;
            end
            else if (REG_ADDR == `APC_ADDR_LOWER)
            begin
                state_next.rdata = state_reg.lower;
            end
            else
            begin
                state_next.rdata = 8'h00;
            end
        end

        // mic pins are asynchronous; stage 0 feeds only stage 1
        state_next.clk_sync = {state_reg.clk_sync[0], MIC_CLK};
        state_next.dat_sync = {state_reg.dat_sync[0], MIC_DATA};
        state_next.clk_prev = state_reg.clk_sync[1];
        if (state_reg.clk_sync[1] && !state_reg.clk_prev)
        begin
            state_next.rise_bit = state_reg.dat_sync[1];
        end
        if (!state_reg.clk_sync[1] && state_reg.clk_prev)
        begin
            state_next.fall_bit = state_reg.dat_sync[1];
        end

        // sign bit: 1 means negative sample
        if (state_reg.lower[`APC_BIT_MIC_SWAP])
        begin
            state_next.mic_sign[0] = state_reg.fall_bit ^ state_reg.lower[`APC_BIT_MIC_POL];
            state_next.mic_sign[1] = state_reg.rise_bit ^ state_reg.lower[`APC_BIT_MIC_POL];
        end
        else
        begin
            state_next.mic_sign[0] = state_reg.rise_bit ^ state_reg.lower[`APC_BIT_MIC_POL];
            state_next.mic_sign[1] = state_reg.fall_bit ^ state_reg.lower[`APC_BIT_MIC_POL];
        end

        if (state_reg.lower[`APC_BIT_DECIM_SRC])
        begin
            state_next.decim_in = state_next.mic_sign;
        end
        else
        begin
            state_next.decim_in = ADC_BIT;
        end

        // half-enabled channels are flagged rather than silently run
        for (int i = 0; i < 2; i++)
        begin
            state_next.ch_active[i] = state_reg.lower[i] & SYNC_EN[i];
            state_next.ch_mismatch[i] = state_reg.lower[i] ^ SYNC_EN[i];
        end

        for (int i = 0; i < 4; i++)
        begin
            if (VOL_BYPASS[i])
            begin
                state_next.vol_applied[i] = `APC_VOL_UNITY;
            end
            else if (channel_muted(state_reg.upper, i))
            begin
                state_next.vol_applied[i] = `APC_VOL_MAX_ATTEN;
            end
            else
            begin
                state_next.vol_applied[i] = ramp_level[i];
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            state_reg <= '{upper: `APC_RST_UPPER, lower: `APC_RST_LOWER, default: '0};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign REG_RDATA     = state_reg.rdata;
    assign VOL_APPLIED   = state_reg.vol_applied;
    assign CAPTURE_RATE  = state_reg.upper[`APC_BIT_RATE_HI:`APC_BIT_RATE_LO];
    assign HIGHPASS_SEL  = state_reg.lower[`APC_BIT_HP_HI:`APC_BIT_HP_LO];
    assign DECIM_SRC_MIC = state_reg.lower[`APC_BIT_DECIM_SRC];
    assign DECIM_IN      = state_reg.decim_in;
    assign MIC_SIGN      = state_reg.mic_sign;
    assign CH_ACTIVE     = state_reg.ch_active;
    assign CH_MISMATCH   = state_reg.ch_mismatch;

    default clocking cb @(posedge CLK); endclocking

    // reset checks must run while reset is high, so they opt out of the default
    a_upper_reset_val: assert property (@(posedge CLK) disable iff (1'b0) SRST
        |=> state_reg.upper == `APC_RST_UPPER && CAPTURE_RATE == `APC_FS_192K)
        else $error("upper control register reset value wrong");
    a_lower_reset_val: assert property (@(posedge CLK) disable iff (1'b0) SRST
        |=> state_reg.lower == `APC_RST_LOWER && HIGHPASS_SEL == 2'h0)
        else $error("lower control register reset value wrong");

    default disable iff (SRST);

    a_mute_max_atten: assert property (state_reg.upper[`APC_BIT_THIRD_MUTE]
        && !VOL_BYPASS[2] |=> VOL_APPLIED[2] == `APC_VOL_MAX_ATTEN)
        else $error("muted third channel not at full attenuation");
    a_mute_fourth_free: assert property (!state_reg.upper[`APC_BIT_FOURTH_MUTE]
        && !VOL_BYPASS[3] |=> VOL_APPLIED[3] == $past(ramp_level[3]))
        else $error("unmuted fourth channel not following its ramp");
    a_bypass_ignores_mute: assert property (VOL_BYPASS[3]
        |=> VOL_APPLIED[3] == `APC_VOL_UNITY)
        else $error("mute acted on a bypassed channel");
    a_rate_field_write: assert property (REG_WR && REG_ADDR == `APC_ADDR_UPPER
        |=> CAPTURE_RATE == $past(REG_WDATA[1:0]))
        else $error("capture rate field did not take the written code");
    a_mic_polarity: assert property (!state_reg.lower[`APC_BIT_MIC_SWAP]
        |=> MIC_SIGN[0] == ($past(state_reg.rise_bit) ^ $past(state_reg.lower[4])))
        else $error("mic left sign wrong for polarity setting");
    a_mic_swap: assert property (state_reg.lower[`APC_BIT_MIC_SWAP]
        |=> MIC_SIGN[0] == ($past(state_reg.fall_bit) ^ $past(state_reg.lower[4])))
        else $error("mic swap did not take left from falling edge");
    a_decim_source: assert property (!state_reg.lower[`APC_BIT_DECIM_SRC]
        |=> DECIM_IN == $past(ADC_BIT))
        else $error("decimator not fed from analog path");
    a_pair_enable: assert property (CH_ACTIVE[1]
        |-> $past(state_reg.lower[1]) && $past(SYNC_EN[1]) && !CH_MISMATCH[1])
        else $error("channel active without both enables");
    a_reserved_readback: assert property (REG_WR && REG_ADDR == `APC_ADDR_LOWER
        ##1 !REG_WR ##1 (REG_RD && !REG_WR && REG_ADDR == `APC_ADDR_LOWER)
        |=> REG_RDATA == $past(REG_WDATA, 3))
        else $error("lower register did not read back as written");
    a_ramp_from_max: assert property ($rose(SYNC_EN[0]) && !VOL_BYPASS[0]
        ##1 !VOL_BYPASS[0] ##1 !VOL_BYPASS[0] |=> VOL_APPLIED[0] == `APC_VOL_MAX_ATTEN)
        else $error("volume ramp did not begin at full attenuation");

    c_unmute_third: cover property ($fell(state_reg.upper[`APC_BIT_THIRD_MUTE]));
    c_swap_on: cover property (state_reg.lower[`APC_BIT_MIC_SWAP] && MIC_SIGN[0]);
    c_mic_source: cover property (DECIM_SRC_MIC && CH_ACTIVE == 2'h3);

endmodule

// [rtl/apc_defs.svh]
`ifndef APC_DEFS_SVH
`define APC_DEFS_SVH

`define APC_ADDR_UPPER      8'h1C
`define APC_ADDR_LOWER      8'h1D
`define APC_RST_UPPER       8'h19
`define APC_RST_LOWER       8'h00

`define APC_BIT_RATE_LO     0
`define APC_BIT_RATE_HI     1
`define APC_BIT_THIRD_MUTE  3
`define APC_BIT_FOURTH_MUTE 4

`define APC_BIT_EN0         0
`define APC_BIT_EN1         1
`define APC_BIT_DECIM_SRC   2
`define APC_BIT_MIC_SWAP    3
`define APC_BIT_MIC_POL     4
`define APC_BIT_HP_LO       5
`define APC_BIT_HP_HI       6

`define APC_FS_96K          2'h0
`define APC_FS_192K         2'h1

`define APC_VOL_MAX_ATTEN   8'hFF
`define APC_VOL_UNITY       8'h00
`define APC_STEP_SAMPLES    16

`endif

// [rtl/apc_pkg.sv]
package apc_pkg;

    typedef logic [3:0][7:0] apc_vol_array_type;

    typedef struct packed {
        logic [7:0]        upper;
        logic [7:0]        lower;
        logic [7:0]        rdata;
        logic [1:0]        clk_sync;
        logic [1:0]        dat_sync;
        logic              clk_prev;
        logic              rise_bit;
        logic              fall_bit;
        logic [1:0]        mic_sign;
        logic [1:0]        decim_in;
        logic [1:0]        ch_active;
        logic [1:0]        ch_mismatch;
        apc_vol_array_type vol_applied;
    } apc_state_type;

    typedef struct packed {
        logic       sync_prev;
        logic [7:0] level;
        logic [7:0] cnt;
    } apc_ramp_state_type;

endpackage

// [rtl/apc_ramp.sv]
`timescale 1ns/1ps
`include "apc_defs.svh"

module apc_ramp
#(
    parameter int STEP_SAMPLES = `APC_STEP_SAMPLES
)
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       sample_tick,
    input  wire logic       sync_en,
    input  wire logic [7:0] target,
    output logic      [7:0] level
);
    import apc_pkg::*;

    localparam logic [7:0] LAST_CNT = 8'(STEP_SAMPLES - 1);

    apc_ramp_state_type state_reg;
    apc_ramp_state_type state_next;

    always_comb
    begin
        state_next = state_reg;
        state_next.sync_prev = sync_en;
        if (!sync_en || !state_reg.sync_prev)
        begin
            // every enable starts from full attenuation
            state_next.level = `APC_VOL_MAX_ATTEN;
            state_next.cnt = 8'h00;
        end
        else if (sample_tick)
        begin
            if (state_reg.cnt == LAST_CNT)
            begin
                state_next.cnt = 8'h00;
                // one 0.375 dB code per step toward the programmed code
                if (state_reg.level > target)
                begin
                    state_next.level = state_reg.level - 8'h01;
                end
                else if (state_reg.level < target)
                begin
                    state_next.level = state_reg.level + 8'h01;
                end
            end
            else
            begin
                state_next.cnt = state_reg.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_reg <= '{sync_prev: 1'b0, level: `APC_VOL_MAX_ATTEN, cnt: 8'h00};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign level = state_reg.level;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_ramp_start_max: assert property ($rose(sync_en) |=> ##1 level == `APC_VOL_MAX_ATTEN)
        else $error("ramp did not start at full attenuation");
    a_ramp_one_step: assert property (sync_en && $past(sync_en) && $changed(level)
        && level != `APC_VOL_MAX_ATTEN |-> (level == $past(level) - 8'h01)
        || (level == $past(level) + 8'h01))
        else $error("ramp moved by more than one code");
    a_ramp_step_spacing: assert property (sync_en && sample_tick
        && state_reg.cnt != LAST_CNT && state_reg.sync_prev |=> level == $past(level))
        else $error("ramp stepped before its sample count elapsed");
    c_ramp_reaches_target: cover property (sync_en && level == target
        && target != `APC_VOL_MAX_ATTEN);

endmodule

// [verification/test_adc_path_control_regs.sv]
`timescale 1ns/1ps
`include "apc_defs.svh"

module test_adc_path_control_regs;
    import apc_pkg::*;

    logic              CLK;
    logic              SRST;
    logic [7:0]        REG_ADDR;
    logic              REG_WR;
    logic [7:0]        REG_WDATA;
    logic              REG_RD;
    logic [7:0]        REG_RDATA;
    logic              SAMPLE_TICK;
    logic [3:0]        SYNC_EN;
    apc_vol_array_type VOL_SET;
    logic [3:0]        VOL_BYPASS;
    logic              MIC_CLK;
    logic              MIC_DATA;
    logic [1:0]        ADC_BIT;
    apc_vol_array_type VOL_APPLIED;
    logic [1:0]        CAPTURE_RATE;
    logic [1:0]        HIGHPASS_SEL;
    logic              DECIM_SRC_MIC;
    logic [1:0]        DECIM_IN;
    logic [1:0]        MIC_SIGN;
    logic [1:0]        CH_ACTIVE;
    logic [1:0]        CH_MISMATCH;
    logic [7:0]        v;
    logic [1:0]        e;
    int                num_errors;
    int                n_compared;

    apc_regs uut
    (
        .CLK           (CLK),
        .SRST          (SRST),
        .REG_ADDR      (REG_ADDR),
        .REG_WR        (REG_WR),
        .REG_WDATA     (REG_WDATA),
        .REG_RD        (REG_RD),
        .REG_RDATA     (REG_RDATA),
        .SAMPLE_TICK   (SAMPLE_TICK),
        .SYNC_EN       (SYNC_EN),
        .VOL_SET       (VOL_SET),
        .VOL_BYPASS    (VOL_BYPASS),
        .MIC_CLK       (MIC_CLK),
        .MIC_DATA      (MIC_DATA),
        .ADC_BIT       (ADC_BIT),
        .VOL_APPLIED   (VOL_APPLIED),
        .CAPTURE_RATE  (CAPTURE_RATE),
        .HIGHPASS_SEL  (HIGHPASS_SEL),
        .DECIM_SRC_MIC (DECIM_SRC_MIC),
        .DECIM_IN      (DECIM_IN),
        .MIC_SIGN      (MIC_SIGN),
        .CH_ACTIVE     (CH_ACTIVE),
        .CH_MISMATCH   (CH_MISMATCH)
    );

    initial
    begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end

    // sample pulse every other cycle, a legal one-cycle strobe
    // free-running, so its phase never races a test's own writes
    initial
    begin
        SAMPLE_TICK = 1'b0;
        forever
        begin
            @(posedge CLK);
            #5 SAMPLE_TICK = ~SAMPLE_TICK;
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #5;
    endtask

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // extra idle cycle keeps the strobe from being driven twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = 1'b1;
        cyc(1);
        REG_WR = 1'b0;
        cyc(1);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        REG_ADDR = a;
        REG_RD = 1'b1;
        cyc(1);
        REG_RD = 1'b0;
        d = REG_RDATA;
        cyc(1);
    endtask

    // data settles well before each pin edge so the synchronisers see it stable
    task automatic mic_frame(input logic r, input logic f);
        MIC_DATA = r;
        cyc(4);
        MIC_CLK = 1'b1;
        cyc(8);
        MIC_DATA = f;
        cyc(4);
        MIC_CLK = 1'b0;
        cyc(8);
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge CLK);
        num_errors++;
        final_report;
    end

    initial
    begin
        num_errors = 0;
        n_compared = 0;
        SRST = 1'b1;
        REG_ADDR = 8'h00;
        REG_WR = 1'b0;
        REG_WDATA = 8'h00;
        REG_RD = 1'b0;
        SYNC_EN = 4'h0;
        VOL_SET = '0;
        VOL_BYPASS = 4'h0;
        MIC_CLK = 1'b0;
        MIC_DATA = 1'b0;
        ADC_BIT = 2'h0;
        cyc(6);
        SRST = 1'b0;
        cyc(2);
        chk("rate", {6'h00, CAPTURE_RATE}, 8'h01);
        chk("vol3", VOL_APPLIED[3], 8'hFF);
        rd(`APC_ADDR_UPPER, v);
        chk("upper", v, 8'h19);
        rd(`APC_ADDR_LOWER, v);
        chk("lower", v, 8'h00);
        rd(8'h1E, v);
        chk("unmapped", v, 8'h00);
        $display("test reset done");

        wr(`APC_ADDR_UPPER, 8'hE4);
        rd(`APC_ADDR_UPPER, v);
        chk("upper rsv", v, 8'hE4);
        chk("rate96", {6'h00, CAPTURE_RATE}, 8'h00);
        wr(`APC_ADDR_UPPER, 8'h1A);
        wr(8'h1E, 8'h55);
        rd(`APC_ADDR_UPPER, v);
        chk("upper code10", v, 8'h1A);
        wr(`APC_ADDR_UPPER, 8'h19);
        chk("rate192", {6'h00, CAPTURE_RATE}, 8'h01);
        wr(`APC_ADDR_LOWER, 8'hE4);
        rd(`APC_ADDR_LOWER, v);
        chk("lower rsv", v, 8'hE4);
        chk("hp", {6'h00, HIGHPASS_SEL}, 8'h03);
        chk("src", {7'h00, DECIM_SRC_MIC}, 8'h01);
        $display("test registers done");

        wr(`APC_ADDR_LOWER, 8'h00);
        ADC_BIT = 2'h2;
        cyc(3);
        chk("decim adc", {6'h00, DECIM_IN}, 8'h02);
        wr(`APC_ADDR_LOWER, 8'h04);
        ADC_BIT = 2'h1;
        cyc(3);
        // no mic clock edge yet, so both mic signs are still zero
        chk("decim mic", {6'h00, DECIM_IN}, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            wr(`APC_ADDR_LOWER, {3'h0, k[1], k[0], 3'h4});
            mic_frame(1'b1, 1'b0);
            e[0] = (k[0] ? 1'b0 : 1'b1) ^ k[1];
            e[1] = (k[0] ? 1'b1 : 1'b0) ^ k[1];
            chk("mic sign", {6'h00, MIC_SIGN}, {6'h00, e});
            chk("decim sign", {6'h00, DECIM_IN}, {6'h00, e});
        end
        $display("test mic done");

        for (int k = 0; k < 4; k++)
        begin
            wr(`APC_ADDR_LOWER, {6'h00, k[1:0]});
            SYNC_EN[1:0] = 2'h2;
            cyc(2);
            chk("active", {6'h00, CH_ACTIVE}, {6'h00, k[1:0] & 2'h2});
            chk("mismatch", {6'h00, CH_MISMATCH}, {6'h00, k[1:0] ^ 2'h2});
        end
        $display("test enables done");

        VOL_BYPASS[3:2] = 2'h3;
        cyc(3);
        chk("bypass mute", VOL_APPLIED[2], `APC_VOL_UNITY);
        chk("bypass mute4", VOL_APPLIED[3], `APC_VOL_UNITY);
        VOL_BYPASS[3:2] = 2'h0;
        wr(`APC_ADDR_UPPER, 8'h11);
        VOL_SET[2] = 8'hFE;
        cyc(1);
        SYNC_EN[2] = 1'b1;
        SYNC_EN[0] = 1'b1;
        // ticks every other cycle: sixteen of them span 32 edges, phase unknown by one
        cyc(32);
        chk("ramp start", VOL_APPLIED[2], 8'hFF);
        chk("ramp start0", VOL_APPLIED[0], 8'hFF);
        cyc(2);
        chk("ramp step", VOL_APPLIED[2], 8'hFE);
        chk("ramp step0", VOL_APPLIED[0], 8'hFE);
        cyc(40);
        chk("ramp hold", VOL_APPLIED[2], 8'hFE);
        wr(`APC_ADDR_UPPER, 8'h19);
        cyc(2);
        chk("mute", VOL_APPLIED[2], `APC_VOL_MAX_ATTEN);
        wr(`APC_ADDR_UPPER, 8'h11);
        cyc(2);
        chk("unmute", VOL_APPLIED[2], 8'hFE);
        chk("other mute", VOL_APPLIED[3], 8'hFF);
        $display("test volume done");
        final_report;
    end
endmodule
